//--- logic/smw_defs.vh
// Purpose: constants for the mode and watchdog controller
// Assumes: 125 MHz i_mclk, 16-bit serial frames
// Notes: definitions only
`ifndef SMW_DEFS_VH
`define SMW_DEFS_VH
// register addresses (7-bit serial address)
`define SMW_ADDR_WD_CTRL 7'h00
`define SMW_ADDR_MODE_REQ 7'h01
`define SMW_ADDR_MAIN_STATUS 7'h03
// mode select codes, field 2:0
`define SMW_MC_SLEEP 3'h1
`define SMW_MC_STANDBY 3'h4
`define SMW_MC_NORMAL 3'h7
// status field positions
`define SMW_ST_OVERTEMP_WARNING_STATUS_BIT 6
`define SMW_ST_NMS_BIT 5
// reset cause codes
`define SMW_RC_POWER_ON 5'h00
`define SMW_RC_CAN_WAKE 5'h01
`define SMW_RC_PIN_WAKE 5'h04
`define SMW_RC_WD_SLEEP 5'h0c
`define SMW_RC_DIAG_WAKE 5'h0d
`define SMW_RC_WD_EARLY 5'h0e
`define SMW_RC_WD_OVERFLOW 5'h0f
`define SMW_RC_WD_ILLEGAL 5'h10
`define SMW_RC_EXT_RESET 5'h11
`define SMW_RC_OVERTEMP 5'h12
`define SMW_RC_SUPPLY_UV 5'h13
`define SMW_RC_ILLEGAL_SLEEP 5'h14
// watchdog mode codes, field 7:5
`define SMW_WMC_AUTO 3'h1
`define SMW_WMC_TIMEOUT 3'h2
`define SMW_WMC_WINDOW 3'h4
// watchdog period codes, field 3:0
`define SMW_NWP_8MS 4'h8
`define SMW_NWP_16MS 4'h1
`define SMW_NWP_32MS 4'h2
`define SMW_NWP_64MS 4'hb
`define SMW_NWP_128MS 4'h4
`define SMW_NWP_256MS 4'hd
`define SMW_NWP_1024MS 4'he
`define SMW_NWP_4096MS 4'h7
// reset values
`define SMW_WMC_RESET 3'h2
`define SMW_NWP_RESET 4'h4
// timing
`define SMW_CLK_HZ 125000000
`define SMW_MS_PER_S 1000
`define SMW_RESET_HOLD_CYCLES 8'h10
`define SMW_FRAME_BITS 5'h10
`define SMW_HDR_BITS 5'h08
`endif

//--- logic/smw_mode_watchdog.v
// Purpose: operating mode sequencer, status and watchdog control
// Assumes: serial port mode 0, frame = 7-bit address, read flag, 8 data bits
// Notes: slow pins pass a two-stage synchroniser before use
// Functional notes
// - leave Reset into Forced Normal when enabled
// - mode codes 001 Sleep, 100 Standby, 111 Normal
// - mode control register at address 0x01
// - reset low in Off/Sleep/Reset/Overtemp; port gated
// - status bit 6 shows overtemperature warning
// - status bit 5 set until Normal reached
// - bits 4:0 hold latest reset cause
// - wake causes 00001, 00100, 01101
// - causes 00000 power-on, 10001 external, 10010 overtemp
// - watchdog causes 01100, 01110, 01111
// - causes 10011 undervoltage, 10100 illegal sleep
// - watchdog modes window, timeout, autonomous
// - window restarts only on well-timed trigger
// - timeout restarts on any trigger; expiry wakes
// - autonomous is off or timeout by state
// - window acts as timeout until Normal
// - mode change in Normal forces reset 10000
// - eight periods from 8 to 4096 ms
// - same period for window and timeout
// - period resets to 128 ms
// - period code to milliseconds mapping
// - invalid codes abandon write, flag failure
// - valid watchdog write restarts timer immediately
// - illegal sleep request forces reset 10100
`include "smw_defs.vh"
`default_nettype none
module smw_mode_watchdog #(
  parameter [31:0] WD_MS_CYCLES = `SMW_CLK_HZ / `SMW_MS_PER_S // cycles per ms
) (
  input wire i_mclk,
  input wire i_reset_n,
  input wire i_clk_en,
  input wire i_spi_sck,
  input wire i_spi_cs_n,
  input wire i_spi_mosi,
  output reg o_spi_miso,
  output wire o_spi_miso_oe,
  input wire i_battery_ok,
  input wire i_overtemp,
  input wire i_overtemp_warning,
  input wire i_can_wake,
  input wire i_wake_pin,
  input wire i_diag_wake,
  input wire i_wake_pending,
  input wire i_host_supply_uv,
  input wire i_reset_out_n,
  output wire o_reset_out_n,
  output wire o_reset_out_n_oe,
  input wire i_forced_normal_enable,
  input wire i_sw_dev_mode,
  input wire i_wake_source_enabled,
  input wire i_spi_fail_enable,
  input wire i_rxd_low,
  output wire [2:0] o_mode,
  output reg o_spi_fail,
  output reg o_watchdog_expired
);
  // operating modes
  localparam [2:0] ST_OFF = 3'h0;
  localparam [2:0] ST_RESET = 3'h1;
  localparam [2:0] ST_FNORMAL = 3'h2;
  localparam [2:0] ST_STANDBY = 3'h3;
  localparam [2:0] ST_NORMAL = 3'h4;
  localparam [2:0] ST_SLEEP = 3'h5;
  localparam [2:0] ST_OVERTEMP = 3'h6;

  // nominal period in ms, 0 marks an invalid code
  function [12:0] period_ms;
    input [3:0] code;
    begin
      case (code)
        `SMW_NWP_8MS: period_ms = 13'h0008;
        `SMW_NWP_16MS: period_ms = 13'h0010;
        `SMW_NWP_32MS: period_ms = 13'h0020;
        `SMW_NWP_64MS: period_ms = 13'h0040;
        `SMW_NWP_128MS: period_ms = 13'h0080;
        `SMW_NWP_256MS: period_ms = 13'h0100;
        `SMW_NWP_1024MS: period_ms = 13'h0400;
        `SMW_NWP_4096MS: period_ms = 13'h1000;
        default: period_ms = 13'h0000;
      endcase
    end
  endfunction

  // watchdog mode code check
  function wmc_valid;
    input [2:0] code;
    begin
      wmc_valid = (code == `SMW_WMC_AUTO) || (code == `SMW_WMC_TIMEOUT) ||
                  (code == `SMW_WMC_WINDOW);
    end
  endfunction

  // synchronisers for pins from outside the clock domain
  wire [11:0] async_in; // raw pins
  reg [11:0] sync1_reg; // first stage, read only by stage two
  reg [11:0] sync2_reg; // usable levels
  assign async_in = {i_spi_sck, i_spi_cs_n, i_spi_mosi, i_battery_ok, i_overtemp,
                     i_overtemp_warning, i_can_wake, i_wake_pin, i_diag_wake,
                     i_wake_pending, i_host_supply_uv, i_reset_out_n};
  // two-flop capture, idle levels at reset
  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync1_reg <= 12'h401;
      sync2_reg <= 12'h401;
    end else if (i_clk_en) begin
      sync1_reg <= async_in;
      sync2_reg <= sync1_reg;
    end
  end
  wire sck_s = sync2_reg[11];
  wire csn_s = sync2_reg[10];
  wire mosi_s = sync2_reg[9];
  wire bat_ok_s = sync2_reg[8];
  wire ot_s = sync2_reg[7];
  wire otw_s = sync2_reg[6];
  wire can_wake_s = sync2_reg[5];
  wire pin_wake_s = sync2_reg[4];
  wire diag_wake_s = sync2_reg[3];
  wire pending_s = sync2_reg[2];
  wire uv_s = sync2_reg[1];
  wire reset_out_n_sense_s = sync2_reg[0];

  // controller state
  reg [2:0] mode_reg; // current operating mode
  reg [4:0] cause_reg; // latest reset cause
  reg nms_reg; // normal not yet reached
  reg [2:0] wmc_reg; // watchdog mode select
  reg [3:0] nwp_reg; // watchdog period select
  reg wdf_reg; // watchdog fail flag
  reg [31:0] wd_cnt_reg; // watchdog timer
  reg [7:0] hold_reg; // reset mode hold counter
  reg [2:0] drv_hist_reg; // recent own pin drive, masks synchroniser lag on release
  assign o_mode = mode_reg;

  // reset pin drive and port availability
  wire reset_out_n_low = (mode_reg == ST_OFF) || (mode_reg == ST_SLEEP) ||
                  (mode_reg == ST_RESET) || (mode_reg == ST_OVERTEMP);
  wire spi_on = (mode_reg == ST_FNORMAL) || (mode_reg == ST_STANDBY) ||
                (mode_reg == ST_NORMAL);
  assign o_reset_out_n = 1'b0;
  assign o_reset_out_n_oe = reset_out_n_low;

  // serial port shift engine
  reg sck_d_reg; // previous sck level
  reg [4:0] bit_cnt_reg; // bits received in frame
  reg [15:0] sh_in_reg; // received frame
  reg [7:0] sh_out_reg; // read data shifter
  reg wr_stb_reg; // one-cycle write commit
  reg [6:0] wr_addr_reg; // committed address
  reg [7:0] wr_data_reg; // committed data
  wire sck_rise = sck_s && !sck_d_reg;
  wire sck_fall = !sck_s && sck_d_reg;
  assign o_spi_miso_oe = !csn_s && spi_on;

  // read data multiplexer, reserved bits zero
  reg [7:0] rd_data;
  always @* begin
    case (sh_in_reg[7:1])
      `SMW_ADDR_WD_CTRL: rd_data = {wmc_reg, 1'b0, nwp_reg};
      `SMW_ADDR_MODE_REQ: begin
        case (mode_reg)
          ST_SLEEP: rd_data = {5'h00, `SMW_MC_SLEEP};
          ST_NORMAL: rd_data = {5'h00, `SMW_MC_NORMAL};
          default: rd_data = {5'h00, `SMW_MC_STANDBY};
        endcase
      end
      `SMW_ADDR_MAIN_STATUS: rd_data = {1'b0, otw_s, nms_reg, cause_reg};
      default: rd_data = 8'h00;
    endcase
  end

  // shift in on rising sck, shift out on falling sck, commit at frame end
  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sck_d_reg <= 1'b0;
      bit_cnt_reg <= 5'h00;
      sh_in_reg <= 16'h0000;
      sh_out_reg <= 8'h00;
      o_spi_miso <= 1'b0;
      wr_stb_reg <= 1'b0;
      wr_addr_reg <= 7'h00;
      wr_data_reg <= 8'h00;
    end else if (i_clk_en) begin
      sck_d_reg <= sck_s;
      wr_stb_reg <= 1'b0;
      if (csn_s) begin
        // frame end: whole write frames only, port must be usable
        if (bit_cnt_reg == `SMW_FRAME_BITS && !sh_in_reg[8] && spi_on) begin
          wr_stb_reg <= 1'b1;
          wr_addr_reg <= sh_in_reg[15:9];
          wr_data_reg <= sh_in_reg[7:0];
        end
        bit_cnt_reg <= 5'h00;
        o_spi_miso <= 1'b0;
      end else begin
        if (sck_rise && bit_cnt_reg != `SMW_FRAME_BITS) begin
          sh_in_reg <= {sh_in_reg[14:0], mosi_s};
          bit_cnt_reg <= bit_cnt_reg + 5'h01;
        end
        if (sck_fall) begin
          if (bit_cnt_reg == `SMW_HDR_BITS) begin
            o_spi_miso <= rd_data[7];
            sh_out_reg <= {rd_data[6:0], 1'b0};
          end else begin
            o_spi_miso <= sh_out_reg[7];
            sh_out_reg <= {sh_out_reg[6:0], 1'b0};
          end
        end
      end
    end
  end

  // effective watchdog behaviour for the current mode
  reg wd_on; // timer running
  reg wd_window; // window behaviour
  always @* begin
    wd_on = 1'b0;
    wd_window = 1'b0;
    case (wmc_reg)
      `SMW_WMC_WINDOW: begin
        wd_on = (mode_reg == ST_NORMAL) || (mode_reg == ST_STANDBY) ||
                (mode_reg == ST_SLEEP);
        wd_window = (mode_reg == ST_NORMAL);
      end
      `SMW_WMC_TIMEOUT: begin
        wd_on = (mode_reg == ST_NORMAL) || (mode_reg == ST_STANDBY) ||
                (mode_reg == ST_SLEEP);
      end
      `SMW_WMC_AUTO: begin
        wd_on = !i_sw_dev_mode && ((mode_reg == ST_NORMAL) ||
                ((mode_reg == ST_STANDBY) && i_rxd_low));
      end
      default: begin
        wd_on = 1'b0;
      end
    endcase
  end

  // timer limit shared by window and timeout behaviour
  wire [31:0] wd_limit = {19'h00000, period_ms(nwp_reg)} * WD_MS_CYCLES;
  wire [31:0] wd_half = {1'b0, wd_limit[31:1]};
  wire wd_expire = wd_on && (wd_cnt_reg >= wd_limit - 32'h00000001);

  // decoded register writes
  wire wr_wd = wr_stb_reg && wr_addr_reg == `SMW_ADDR_WD_CTRL && mode_reg != ST_FNORMAL;
  wire wr_mode = wr_stb_reg && wr_addr_reg == `SMW_ADDR_MODE_REQ && mode_reg != ST_FNORMAL;
  wire wd_code_ok = wmc_valid(wr_data_reg[7:5]) && (period_ms(wr_data_reg[3:0]) != 13'h0000);
  wire [2:0] mc_req = wr_data_reg[2:0];
  wire mc_known = mc_req == `SMW_MC_SLEEP || mc_req == `SMW_MC_STANDBY ||
                  mc_req == `SMW_MC_NORMAL;

  // mode sequencer, reset cause capture and watchdog timer
  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode_reg <= ST_OFF;
      cause_reg <= `SMW_RC_POWER_ON;
      nms_reg <= 1'b1;
      wmc_reg <= `SMW_WMC_RESET;
      nwp_reg <= `SMW_NWP_RESET;
      wdf_reg <= 1'b0;
      wd_cnt_reg <= 32'h00000000;
      hold_reg <= 8'h00;
      drv_hist_reg <= 3'h7;
      o_spi_fail <= 1'b0;
      o_watchdog_expired <= 1'b0;
    end else if (i_clk_en) begin
      // released pin needs three cycles before its sensed level is trusted
      drv_hist_reg <= {drv_hist_reg[1:0], reset_out_n_low};
      o_spi_fail <= 1'b0;
      o_watchdog_expired <= 1'b0;
      // timer runs only while enabled
      if (wd_on) begin
        wd_cnt_reg <= wd_cnt_reg + 32'h00000001;
      end else begin
        wd_cnt_reg <= 32'h00000000;
      end
      if (!bat_ok_s) begin
        // battery lost: back to off from anywhere
        mode_reg <= ST_OFF;
      end else if (mode_reg == ST_OFF) begin
        mode_reg <= ST_RESET; // leave off at power-on
        hold_reg <= 8'h00;
        cause_reg <= `SMW_RC_POWER_ON;
        nms_reg <= 1'b1;
      end else if (ot_s && mode_reg != ST_SLEEP) begin
        mode_reg <= ST_OVERTEMP; // overtemperature overrides
      end else if (mode_reg == ST_OVERTEMP) begin
        mode_reg <= ST_RESET; // cooled down
        hold_reg <= 8'h00;
        cause_reg <= `SMW_RC_OVERTEMP;
      end else if (uv_s && mode_reg != ST_SLEEP) begin
        mode_reg <= ST_RESET; // held in reset while supply is low
        hold_reg <= 8'h00;
        cause_reg <= `SMW_RC_SUPPLY_UV;
      end else if (!reset_out_n_sense_s && !reset_out_n_low && drv_hist_reg == 3'h0) begin
        mode_reg <= ST_RESET; // pin pulled low from outside
        hold_reg <= 8'h00;
        cause_reg <= `SMW_RC_EXT_RESET;
      end else begin
        case (mode_reg)
          ST_RESET: begin
            if (hold_reg == `SMW_RESET_HOLD_CYCLES) begin
              mode_reg <= i_forced_normal_enable ? ST_FNORMAL : ST_STANDBY;
            end else begin
              hold_reg <= hold_reg + 8'h01;
            end
          end
          ST_SLEEP: begin
            // wake-ups leave sleep through reset
            if (can_wake_s || pin_wake_s || diag_wake_s || wd_expire) begin
              mode_reg <= ST_RESET;
              hold_reg <= 8'h00;
              wd_cnt_reg <= 32'h00000000;
              if (can_wake_s) begin
                cause_reg <= `SMW_RC_CAN_WAKE;
              end else if (pin_wake_s) begin
                cause_reg <= `SMW_RC_PIN_WAKE;
              end else if (diag_wake_s) begin
                cause_reg <= `SMW_RC_DIAG_WAKE;
              end else begin
                cause_reg <= `SMW_RC_WD_SLEEP;
              end
            end
          end
          ST_STANDBY, ST_NORMAL: begin
            if (wr_wd) begin
              if (!wd_code_ok) begin
                o_spi_fail <= i_spi_fail_enable;
              end else if (mode_reg == ST_NORMAL && wr_data_reg[7:5] != wmc_reg) begin
                mode_reg <= ST_RESET;
                hold_reg <= 8'h00;
                cause_reg <= `SMW_RC_WD_ILLEGAL;
              end else if (wd_window && wd_cnt_reg < wd_half) begin
                mode_reg <= ST_RESET; // trigger too early
                hold_reg <= 8'h00;
                cause_reg <= `SMW_RC_WD_EARLY;
              end else begin
                wmc_reg <= wr_data_reg[7:5];
                nwp_reg <= wr_data_reg[3:0];
                wd_cnt_reg <= 32'h00000000;
                wdf_reg <= 1'b0;
              end
            end else if (wd_expire) begin
              wd_cnt_reg <= 32'h00000000;
              if (wd_window || wdf_reg) begin
                mode_reg <= ST_RESET;
                hold_reg <= 8'h00;
                cause_reg <= `SMW_RC_WD_OVERFLOW;
              end else begin
                wdf_reg <= 1'b1; // first timeout overflow
                o_watchdog_expired <= 1'b1;
              end
            end else if (wr_mode && mc_known) begin
              if (mc_req == `SMW_MC_SLEEP) begin
                if (pending_s || !i_wake_source_enabled) begin
                  mode_reg <= ST_RESET;
                  hold_reg <= 8'h00;
                  cause_reg <= `SMW_RC_ILLEGAL_SLEEP;
                end else begin
                  mode_reg <= ST_SLEEP;
                end
              end else if (mc_req == `SMW_MC_NORMAL) begin
                mode_reg <= ST_NORMAL;
                nms_reg <= 1'b0;
              end else begin
                mode_reg <= ST_STANDBY;
              end
            end
          end
          default: begin
            mode_reg <= mode_reg; // forced normal waits for reset events
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

//--- verif/smw_mode_watchdog_chk.sv
// Purpose: port-level checks of the mode and watchdog controller
// Assumes: one clock, async active-low reset
// Notes: bound to the design top after the module
`default_nettype none
module smw_mode_watchdog_chk (
  input wire i_mclk,
  input wire i_reset_n,
  input wire i_spi_cs_n,
  input wire i_spi_fail_enable,
  input wire i_reset_out_n,
  input wire i_forced_normal_enable,
  input wire o_spi_miso_oe,
  input wire o_reset_out_n,
  input wire o_reset_out_n_oe,
  input wire [2:0] o_mode,
  input wire o_spi_fail,
  input wire o_watchdog_expired
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_reset_n);
  // pin pulled low exactly in the holding modes
  a_reset_pin_mode: assert property (o_reset_out_n_oe == (o_mode inside {3'h0, 3'h1, 3'h5, 3'h6})
    && !o_reset_out_n) else $error("reset pin drive does not follow mode");
  // serial output only in usable modes
  a_port_gated: assert property (o_spi_miso_oe |-> o_mode inside {3'h2, 3'h3, 3'h4})
    else $error("serial output enabled in a disabled mode");
  // deselected port lets go of its output
  a_port_idle: assert property (i_spi_cs_n [*4] |-> !o_spi_miso_oe)
    else $error("serial output driven while deselected");
  // leaving reset picks forced normal or standby
  a_forced_exit: assert property ((o_mode == 3'h1 ##1 o_mode inside {3'h2, 3'h3})
    |-> o_mode == ($past(i_forced_normal_enable) ? 3'h2 : 3'h3))
    else $error("wrong mode after reset");
  // normal only reached from standby
  a_normal_entry: assert property ((o_mode == 3'h4 && $past(o_mode) != 3'h4)
    |-> $past(o_mode) == 3'h3) else $error("normal entered from wrong mode");
  // sleep only reached from standby or normal
  a_sleep_entry: assert property ($rose(o_mode == 3'h5) |-> $past(o_mode) inside {3'h3, 3'h4})
    else $error("sleep entered from wrong mode");
  // expiry only where the timer runs, single pulse
  a_expiry_mode: assert property (o_watchdog_expired
    |-> $past(o_mode) inside {3'h3, 3'h4, 3'h5} ##1 !o_watchdog_expired)
    else $error("watchdog expiry in a stopped mode");
  // failure pulse only when enabled and port writable
  a_fail_gate: assert property (o_spi_fail |-> $past(i_spi_fail_enable) && $past(o_mode) inside
    {3'h3, 3'h4}) else $error("serial failure pulse not allowed here");
  // external pull on the reset pin forces reset quickly
  a_ext_reset: assert property ((!i_reset_out_n && o_mode == 3'h3) [*3]
    |-> ##[1:4] o_mode inside {3'h0, 3'h1, 3'h6}) else $error("external reset ignored");
endmodule
bind smw_mode_watchdog smw_mode_watchdog_chk smw_mode_watchdog_chk_i (.i_mclk(i_mclk),
  .i_reset_n(i_reset_n), .i_spi_cs_n(i_spi_cs_n), .i_spi_fail_enable(i_spi_fail_enable),
  .i_reset_out_n(i_reset_out_n), .i_forced_normal_enable(i_forced_normal_enable),
  .o_spi_miso_oe(o_spi_miso_oe), .o_reset_out_n(o_reset_out_n),
  .o_reset_out_n_oe(o_reset_out_n_oe), .o_mode(o_mode), .o_spi_fail(o_spi_fail),
  .o_watchdog_expired(o_watchdog_expired));
`default_nettype wire

//--- verif/smw_host_model.sv
// Purpose: host controller driving serial frames
// Assumes: mode 0 frames, msb first, slow sck
// Notes: released data line shows the inverse of its last bit
`default_nettype none
module smw_host_model #(
  parameter int HALF = 6 // mclk cycles per sck half period
) (
  input wire logic i_mclk,
  input wire logic i_miso,
  output logic o_sck,
  output logic o_cs_n,
  output logic o_mosi
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus at time zero
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end
  // move just after an edge
  task automatic step(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  // one whole frame, read data caught before each rise
  task automatic xfer(input logic [6:0] a, input logic rd, input logic [7:0] d,
                      output logic [7:0] q);
    logic [15:0] f;
    int k;
    f = {a, rd, d};
    q = 8'h00;
    step(1);
    o_cs_n = 1'b0;
    for (k = 15; k >= 0; k--) begin
      o_mosi = f[k];
      step(HALF);
      if (k < 8) q[k] = i_miso;
      o_sck = 1'b1;
      step(HALF);
      o_sck = 1'b0;
    end
    step(HALF);
    o_cs_n = 1'b1;
    o_mosi = ~o_mosi; // released line
    step(8); // gap between frames
  endtask
endmodule
`default_nettype wire

//--- verif/tb.sv
// Purpose: self-checking bench of the mode and watchdog controller
// Assumes: watchdog ms shortened to 128 cycles
// Notes: events come from a table, warning level is random
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_mclk = 1'b0;
  logic i_reset_n = 1'b0;
  logic otw = 1'b0; // warning level
  logic fne = 1'b0; // forced normal enable
  logic wake_en = 1'b1;
  logic pend = 1'b0;
  logic fail_en = 1'b0;
  logic [6:0] ev = 7'h00; // battery low, overtemp, uv, ext, can, pin, diag
  logic miso_float = 1'b0;
  logic [31:0] rnd;
  wire sck, cs_n, mosi, miso, miso_oe, rst_out, rst_oe, sfail, wexp;
  wire [2:0] o_mode;
  int n_fail = 0;
  int checked = 0;
  int n_exp = 0;
  int n_sfail = 0;
  int e0;
  logic [3:0] watchdog_period_select [8] = '{4'h8, 4'h1, 4'h2, 4'hb, 4'h4, 4'hd, 4'he, 4'h7};
  logic [6:0] evt [7] = '{7'h08, 7'h20, 7'h10, 7'h04, 7'h02, 7'h01, 7'h40};
  logic [4:0] cause [7] = '{5'h11, 5'h12, 5'h13, 5'h01, 5'h04, 5'h0d, 5'h00};
  // pin levels seen by all parties, reset pin pulled up
  wire rst_pin = rst_oe ? rst_out : ~ev[3];
  wire miso_pin = miso_oe ? miso : miso_float;
  always #4 i_mclk = ~i_mclk;
  // undriven data line changes every cycle; pulse counters
  always @(posedge i_mclk) begin
    miso_float <= ~miso_float;
    if (wexp === 1'b1) n_exp++;
    if (sfail === 1'b1) n_sfail++;
  end
  smw_host_model smw_host_model_i (.i_mclk(i_mclk), .i_miso(miso_pin), .o_sck(sck),
    .o_cs_n(cs_n), .o_mosi(mosi));
  smw_mode_watchdog #(.WD_MS_CYCLES(32'd128)) smw_mode_watchdog_i (.i_mclk(i_mclk),
    .i_reset_n(i_reset_n), .i_clk_en(1'b1), .i_spi_sck(sck), .i_spi_cs_n(cs_n),
    .i_spi_mosi(mosi), .o_spi_miso(miso), .o_spi_miso_oe(miso_oe), .i_battery_ok(~ev[6]),
    .i_overtemp(ev[5]), .i_overtemp_warning(otw), .i_can_wake(ev[2]), .i_wake_pin(ev[1]),
    .i_diag_wake(ev[0]), .i_wake_pending(pend), .i_host_supply_uv(ev[4]),
    .i_reset_out_n(rst_pin), .o_reset_out_n(rst_out), .o_reset_out_n_oe(rst_oe),
    .i_forced_normal_enable(fne), .i_sw_dev_mode(1'b0), .i_wake_source_enabled(wake_en),
    .i_spi_fail_enable(fail_en), .i_rxd_low(1'b0), .o_mode(o_mode), .o_spi_fail(sfail),
    .o_watchdog_expired(wexp));
  // expected main status word
  function automatic logic [7:0] st(input logic normal_not_yet_reached, input logic [4:0] c);
    return {1'b0, otw, normal_not_yet_reached, c};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  // write frame, then let the commit land
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    smw_host_model_i.xfer(a, 1'b0, d, q);
    cyc(4);
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] q;
    smw_host_model_i.xfer(a, 1'b1, 8'h00, q);
    `CHK(q, e)
  endtask
  // bounded wait for a mode
  task automatic wait_mode(input logic [2:0] m);
    int k;
    for (k = 0; k < 6000 && o_mode !== m; k++) cyc(1);
    `CHK(o_mode, m)
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // main sequence
  initial begin
    rnd = $urandom(32'ha53f);
    cyc(10);
    i_reset_n = 1'b1;
    wait_mode(3'h3);
    rd_chk(7'h03, st(1'b1, 5'h00));
    rd_chk(7'h00, 8'h44);
    rd_chk(7'h01, 8'h04);
    rd_chk(7'h7f, 8'h00);
    repeat (3) begin
      rnd = $urandom;
      otw = rnd[0];
      rd_chk(7'h03, st(1'b1, 5'h00));
    end
    for (int k = 0; k < 8; k++) begin
      wr(7'h00, {3'h2, 1'b0, watchdog_period_select[k]});
      rd_chk(7'h00, {3'h2, 1'b0, watchdog_period_select[k]});
    end
    fail_en = 1'b1;
    e0 = n_sfail;
    wr(7'h00, 8'h49);
    wr(7'h00, 8'h67);
    rd_chk(7'h00, 8'h47);
    `CHK(n_sfail - e0, 2)
    wr(7'h01, 8'hff);
    wait_mode(3'h4);
    rd_chk(7'h01, 8'h07);
    rd_chk(7'h03, st(1'b0, 5'h00));
    wr(7'h00, 8'h87);
    wait_mode(3'h1);
    wait_mode(3'h3);
    rd_chk(7'h03, st(1'b0, 5'h10));
    wr(7'h00, 8'h81);
    e0 = n_exp;
    cyc(2300);
    `CHK(n_exp - e0, 1)
    wr(7'h00, 8'h81);
    wr(7'h01, 8'h07);
    cyc(1000);
    wr(7'h00, 8'h81);
    `CHK(o_mode, 3'h4)
    wr(7'h00, 8'h81);
    wait_mode(3'h1);
    wait_mode(3'h3);
    rd_chk(7'h03, st(1'b0, 5'h0e));
    e0 = n_exp;
    repeat (6) wr(7'h00, 8'h48);
    `CHK(n_exp - e0, 0)
    cyc(2200);
    wait_mode(3'h3);
    rd_chk(7'h03, st(1'b0, 5'h0f));
    `CHK(n_exp > e0, 1'b1)
    wr(7'h00, 8'h48);
    wr(7'h01, 8'h01);
    wait_mode(3'h5);
    wait_mode(3'h1);
    wait_mode(3'h3);
    rd_chk(7'h03, st(1'b0, 5'h0c));
    wr(7'h00, 8'h47);
    for (int k = 0; k < 2; k++) begin
      wake_en = (k == 0) ? 1'b0 : 1'b1;
      pend = (k == 1);
      wr(7'h01, 8'h01);
      wait_mode(3'h1);
      wait_mode(3'h3);
      rd_chk(7'h03, st(1'b0, 5'h14));
    end
    pend = 1'b0;
    fne = 1'b1;
    ev = 7'h08;
    cyc(8);
    ev = 7'h00;
    wait_mode(3'h2);
    rd_chk(7'h03, st(1'b0, 5'h11));
    fne = 1'b0;
    for (int k = 0; k < 7; k++) begin
      if (k >= 3 && k <= 5) begin
        wr(7'h01, 8'h01);
        wait_mode(3'h5);
      end
      ev = evt[k];
      cyc(8);
      ev = 7'h00;
      wait_mode(3'h3);
      rd_chk(7'h03, st(k == 6, cause[k]));
    end
    tally_and_finish();
  end
  // hang guard, well beyond the expected run
  initial begin
    repeat (90000) @(posedge i_mclk);
    n_fail++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
